// ===== common/ahsp_pkg.sv
// shared constants and carriers of the host signal port
package ahsp_pkg;
  localparam int          DATA_W       = 16;
  localparam int          ADDR_W       = 3;
  localparam int          PIN_W        = 11;
  // ------------------------------------------------------------------
  // register addresses inside a block
  // ------------------------------------------------------------------
  localparam logic [2:0]  ADDR_STATCMD = 3'h7;
  localparam logic [2:0]  ADDR_DEVCTL  = 3'h6;
  // ------------------------------------------------------------------
  // pacing and phase counts, in sys clock cycles
  // ------------------------------------------------------------------
  localparam logic [3:0]  DIN_GAP      = 4'h2;
  localparam int          PRESENCE_CYC = 1024;
  // ------------------------------------------------------------------
  // reset values of the synchronised pin bundle
  // {hrst_n, pdiag_n, dasp_n, csel, dmack_n, wr_n, rd_n, cs_cmd_n, cs_ctl_n, addr[1:0]}
  // ------------------------------------------------------------------
  localparam logic [PIN_W-1:0] PIN_RST = 11'h7fc;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  typedef enum logic [1:0] {ST_IDLE, ST_DIN, ST_DOUT} ahsp_burst_e;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic              ctl_blk;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ahsp_reg_acc_s;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } ahsp_word_s;
endpackage

// ===== rtl/ahsp_sync.sv
// two flip-flop synchroniser for a bundle of levels
module ahsp_sync #(
  parameter int                W       = 1,
  parameter logic [W-1:0]      RST_VAL = '0
) (
  input  wire logic            i_clk,
  input  wire logic            i_rst,
  input  wire logic [W-1:0]    i_d,
  output logic      [W-1:0]    o_q
);
  logic [W-1:0] meta_reg;

  if (W < 1)
  begin
    $error("ahsp_sync: width must be at least one");
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      meta_reg <= RST_VAL;
      o_q      <= RST_VAL;
    end
    else
    begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end
endmodule

// ===== rtl/ahsp_link_cap.sv
// link clock side: captures data-out words on both host strobe edges
module ahsp_link_cap (
  input  wire logic                        i_clk_link,
  input  wire logic                        i_rst_sys,
  input  wire logic                        i_arm,
  input  wire logic                        i_strobe,
  input  wire logic [ahsp_pkg::DATA_W-1:0] i_data,
  output logic      [ahsp_pkg::DATA_W-1:0] o_word,
  output logic                             o_tgl
);
  logic       rst1_reg, rst2_reg, arm1_reg, arm2_reg;
  logic       stb1_reg, stb2_reg, stb3_reg;
  logic [ahsp_pkg::DATA_W-1:0] d1_reg, d2_reg;
  logic       edge_seen;

  // ------------------------------------------------------------------
  // crossings into the link domain
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk_link)
  begin
    rst1_reg <= i_rst_sys;
    rst2_reg <= rst1_reg;
    arm1_reg <= i_arm;
    arm2_reg <= arm1_reg;
    stb1_reg <= i_strobe;
    stb2_reg <= stb1_reg;
    stb3_reg <= stb2_reg;
    d1_reg   <= i_data;
    d2_reg   <= d1_reg;
  end

  // data and strobe see the same delay, so the word pairs with its edge
  assign edge_seen = stb2_reg ^ stb3_reg;

  always_ff @(posedge i_clk_link)
  begin
    if (rst2_reg)
    begin
      o_word <= ahsp_pkg::DATA_RST;
      o_tgl  <= 1'b0;
    end
    else if (arm2_reg && edge_seen)
    begin
      // no edge simply means no word: a pause needs no handling
      o_word <= d2_reg;
      o_tgl  <= ~o_tgl;
    end
  end

  property p_cap_edge;
    @(posedge i_clk_link) disable iff (rst2_reg)
    (arm2_reg && edge_seen) |=> (o_tgl != $past(o_tgl)) && (o_word == $past(d2_reg));
  endproperty
  a_cap_edge: assert property (p_cap_edge) else $error("edge not captured");

  property p_cap_idle;
    @(posedge i_clk_link) disable iff (rst2_reg)
    !edge_seen |=> $stable(o_tgl);
  endproperty
  a_cap_idle: assert property (p_cap_idle) else $error("word without edge");
endmodule

// ===== rtl/ahsp_top.sv
// device end of the parallel host port: decode, udma strobing, irq, diag lines
// What this block does
// - host ready negated pauses data-in strobing
// - data-out word captured on both strobe edges
// - irq negated on reset, srst, command write
// - irq negated on status read, sector done
// - irq released when unselected or disabled
// - first chip select picks command block
// - second chip select picks control block
// - three address bits pick block register
// - diag line input on master, output slave
// - slave asserts diag done, master samples
// - activity line multiplexes presence then activity
// - stop line ends a udma burst
// - grounded cable select means master
module ahsp_top #(
  parameter int PRESENCE_CYC = ahsp_pkg::PRESENCE_CYC
) (
  input  wire logic                         i_clk_sys,
  input  wire logic                         i_sys_rst,
  input  wire logic                         i_clk_link,
  input  wire logic                         i_hrst_n,
  input  wire logic                         i_cs_cmd_n,
  input  wire logic                         i_cs_ctl_n,
  input  wire logic [ahsp_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic                         i_rd_n,
  input  wire logic                         i_wr_n,
  input  wire logic                         i_dmack_n,
  input  wire logic                         i_csel,
  input  wire logic [ahsp_pkg::DATA_W-1:0]  i_data,
  output logic      [ahsp_pkg::DATA_W-1:0]  o_data,
  output logic                              o_data_oe,
  output logic                              o_ddmardy_n,
  output logic                              o_dstrobe,
  output logic                              o_intrq,
  output logic                              o_intrq_oe,
  input  wire logic                         i_pdiag_n,
  output logic                              o_pdiag_n,
  output logic                              o_pdiag_oe,
  input  wire logic                         i_dasp_n,
  output logic                              o_dasp_n,
  output logic                              o_dasp_oe,
  input  wire logic [ahsp_pkg::DATA_W-1:0]  i_reg_rdata,
  output ahsp_pkg::ahsp_reg_acc_s           o_reg_acc,
  input  wire logic                         i_int_set,
  input  wire logic                         i_int_en,
  input  wire logic                         i_dev_sel,
  input  wire logic                         i_srst,
  input  wire logic                         i_sector_done,
  input  wire logic                         i_diag_done,
  input  wire logic                         i_active,
  input  wire logic                         i_din_start,
  input  wire logic                         i_din_valid,
  input  wire logic [ahsp_pkg::DATA_W-1:0]  i_din_data,
  output logic                              o_din_take,
  input  wire logic                         i_dout_start,
  input  wire logic                         i_dout_ready,
  output ahsp_pkg::ahsp_word_s              o_dout_word,
  output logic                              o_burst_stop,
  output logic                              o_is_master,
  output logic                              o_peer_diag_ok,
  output logic                              o_peer_present
);
  localparam int PCNT_W = $clog2(PRESENCE_CYC + 1);

  logic [ahsp_pkg::PIN_W-1:0]  pin_s;
  logic [ahsp_pkg::DATA_W-1:0] data_s, link_word;
  logic        hrst_s, pdiag_s, dasp_s, csel_s, dmack_s, wr_s, rd_s, cs_cmd_s, cs_ctl_s;
  logic [2:0]  addr_s;
  logic [1:0]  addr_lo_s, settle_reg;
  logic        rst_int, cmd_sel, ctl_sel, rd_act, rd_act_reg, wr_reg, addr_hi_s;
  logic        rd_pulse, wr_pulse, stat_rd, cmd_wr;
  logic        strap_done_reg, due_reg, tgl_s, tgl_reg, link_tgl;
  logic [3:0]  pace_reg;
  logic [PCNT_W-1:0] pcnt_reg;
  ahsp_pkg::ahsp_burst_e state_reg;

  if (PRESENCE_CYC < 1)
  begin
    $error("ahsp_top: presence phase must be at least one cycle");
  end

  // ------------------------------------------------------------------
  // pin synchronisation
  // ------------------------------------------------------------------
  ahsp_sync #(.W(ahsp_pkg::PIN_W), .RST_VAL(ahsp_pkg::PIN_RST)) u_sync_pin (
    .i_clk (i_clk_sys),
    .i_rst (i_sys_rst),
    .i_d   ({i_hrst_n, i_pdiag_n, i_dasp_n, i_csel, i_dmack_n, i_wr_n, i_rd_n,
             i_cs_cmd_n, i_cs_ctl_n, i_addr[1:0]}),
    .o_q   (pin_s)
  );
  ahsp_sync #(.W(ahsp_pkg::DATA_W + 2), .RST_VAL('0)) u_sync_data (
    .i_clk (i_clk_sys),
    .i_rst (i_sys_rst),
    .i_d   ({i_data, i_addr[2], link_tgl}),
    .o_q   ({data_s, addr_hi_s, tgl_s})
  );

  assign {hrst_s, pdiag_s, dasp_s, csel_s, dmack_s, wr_s, rd_s,
          cs_cmd_s, cs_ctl_s, addr_lo_s} = pin_s;
  assign addr_s = {addr_hi_s, addr_lo_s};

  // host reset pin resets the port like the system reset
  assign rst_int = i_sys_rst | ~hrst_s;

  // ------------------------------------------------------------------
  // register access decode
  // ------------------------------------------------------------------
  assign cmd_sel  = ~cs_cmd_s & cs_ctl_s;
  assign ctl_sel  = cs_cmd_s & ~cs_ctl_s;
  assign rd_act   = ~rd_s & (cmd_sel | ctl_sel) & dmack_s & (state_reg == ahsp_pkg::ST_IDLE);
  assign rd_pulse = rd_act & ~rd_act_reg;
  // write taken at the trailing edge, when data has settled
  assign wr_pulse = wr_s & ~wr_reg & (cmd_sel | ctl_sel) & dmack_s;
  assign stat_rd  = rd_pulse & cmd_sel & (addr_s == ahsp_pkg::ADDR_STATCMD);
  assign cmd_wr   = wr_pulse & cmd_sel & (addr_s == ahsp_pkg::ADDR_STATCMD);

  always_ff @(posedge i_clk_sys)
  begin
    if (rst_int)
    begin
      rd_act_reg <= 1'b0;
      wr_reg     <= 1'b1;
      o_reg_acc  <= '0;
    end
    else
    begin
      rd_act_reg        <= rd_act;
      wr_reg            <= wr_s;
      o_reg_acc.valid   <= rd_pulse | wr_pulse;
      o_reg_acc.write   <= wr_pulse;
      o_reg_acc.ctl_blk <= ctl_sel;
      o_reg_acc.addr    <= addr_s;
      o_reg_acc.wdata   <= data_s;
    end
  end

  // ------------------------------------------------------------------
  // burst control
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (rst_int)
      state_reg <= ahsp_pkg::ST_IDLE;
    else
      case (state_reg)
        ahsp_pkg::ST_IDLE:
          // write strobe low doubles as stop negated at burst start
          if (~dmack_s && ~wr_s && i_din_start)
            state_reg <= ahsp_pkg::ST_DIN;
          else if (~dmack_s && ~wr_s && i_dout_start)
            state_reg <= ahsp_pkg::ST_DOUT;
        ahsp_pkg::ST_DIN, ahsp_pkg::ST_DOUT:
          if (wr_s || dmack_s)
            state_reg <= ahsp_pkg::ST_IDLE;
        default:
          state_reg <= ahsp_pkg::ST_IDLE;
      endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (rst_int)
      o_burst_stop <= 1'b0;
    else
      o_burst_stop <= (state_reg != ahsp_pkg::ST_IDLE) && wr_s;
  end

  // ------------------------------------------------------------------
  // data-in strobing and bus drive
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (rst_int)
    begin
      o_data     <= ahsp_pkg::DATA_RST;
      o_data_oe  <= 1'b0;
      o_dstrobe  <= 1'b0;
      o_din_take <= 1'b0;
      due_reg    <= 1'b0;
      pace_reg   <= '0;
    end
    else
    begin
      o_din_take <= 1'b0;
      o_data_oe  <= rd_act || (state_reg == ahsp_pkg::ST_DIN);
      if (state_reg != ahsp_pkg::ST_DIN)
      begin
        due_reg  <= 1'b0;
        pace_reg <= '0;
        if (rd_act)
          o_data <= i_reg_rdata;
      end
      else if (due_reg)
      begin
        // data leads the strobe edge by a cycle for host setup
        o_dstrobe <= ~o_dstrobe;
        due_reg   <= 1'b0;
        pace_reg  <= ahsp_pkg::DIN_GAP;
      end
      else if (pace_reg != '0)
        pace_reg <= pace_reg - 4'h1;
      else if (~rd_s && i_din_valid && ~wr_s)
      begin
        o_data     <= i_din_data;
        o_din_take <= 1'b1;
        due_reg    <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // data-out flow control and word crossing
  // ------------------------------------------------------------------
  ahsp_link_cap u_link (
    .i_clk_link (i_clk_link),
    .i_rst_sys  (rst_int),
    .i_arm      (state_reg == ahsp_pkg::ST_DOUT),
    .i_strobe   (i_rd_n),
    .i_data     (i_data),
    .o_word     (link_word),
    .o_tgl      (link_tgl)
  );

  // word is read several link edges after it settled; the host strobe
  // rate must stay below the toggle crossing rate
  always_ff @(posedge i_clk_sys)
  begin
    if (rst_int)
    begin
      tgl_reg     <= 1'b0;
      o_dout_word <= '0;
      o_ddmardy_n <= 1'b1;
    end
    else
    begin
      tgl_reg           <= tgl_s;
      o_dout_word.valid <= tgl_s ^ tgl_reg;
      if (tgl_s ^ tgl_reg)
        o_dout_word.data <= link_word;
      o_ddmardy_n <= ~((state_reg == ahsp_pkg::ST_DOUT) && i_dout_ready);
    end
  end

  // ------------------------------------------------------------------
  // interrupt request
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (rst_int || i_srst)
      o_intrq <= 1'b0;
    else if (i_int_set)
      o_intrq <= 1'b1;
    else if (cmd_wr || stat_rd || i_sector_done)
      o_intrq <= 1'b0;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (rst_int)
      o_intrq_oe <= 1'b0;
    else
      o_intrq_oe <= i_dev_sel && i_int_en;
  end

  // ------------------------------------------------------------------
  // strap, diagnostics and activity lines
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (rst_int)
    begin
      strap_done_reg <= 1'b0;
      o_is_master    <= 1'b0;
      settle_reg     <= '0;
    end
    else
    begin
      // strap from the pin, not from the synchroniser's reset value
      settle_reg <= {settle_reg[0], 1'b1};
      if (settle_reg[1] && !strap_done_reg)
      begin
        strap_done_reg <= 1'b1;
        o_is_master    <= ~csel_s;
      end
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (rst_int)
    begin
      o_pdiag_n      <= 1'b1;
      o_pdiag_oe     <= 1'b0;
      o_peer_diag_ok <= 1'b0;
    end
    else
    begin
      o_pdiag_n      <= 1'b0;
      o_pdiag_oe     <= strap_done_reg && !o_is_master && i_diag_done;
      o_peer_diag_ok <= o_is_master && !pdiag_s;
    end
  end

  // presence phase first, then the line shows activity
  always_ff @(posedge i_clk_sys)
  begin
    if (rst_int)
    begin
      pcnt_reg       <= '0;
      o_dasp_n       <= 1'b1;
      o_dasp_oe      <= 1'b0;
      o_peer_present <= 1'b0;
    end
    else
    begin
      o_dasp_n <= 1'b0;
      if (pcnt_reg != PCNT_W'(PRESENCE_CYC))
      begin
        pcnt_reg  <= pcnt_reg + PCNT_W'(1);
        o_dasp_oe <= strap_done_reg && !o_is_master;
        if (o_is_master && !dasp_s)
          o_peer_present <= 1'b1;
      end
      else
        o_dasp_oe <= i_active;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (rst_int);

  property p_irq_hrst;
    @(posedge i_clk_sys) disable iff (i_sys_rst) !hrst_s |=> !o_intrq;
  endproperty
  a_irq_hrst: assert property (p_irq_hrst) else $error("irq kept over reset");
  property p_irq_stat;
    stat_rd && !i_int_set |=> !o_intrq;
  endproperty
  a_irq_stat: assert property (p_irq_stat) else $error("irq kept after status read");
  property p_irq_oe;
    !(i_dev_sel && i_int_en) |=> !o_intrq_oe;
  endproperty
  a_irq_oe: assert property (p_irq_oe) else $error("irq driven while released");
  property p_blk;
    rd_pulse |=> o_reg_acc.valid && (o_reg_acc.ctl_blk == $past(ctl_sel));
  endproperty
  a_blk: assert property (p_blk) else $error("wrong register block");
  property p_addr;
    (rd_pulse || wr_pulse) |=> o_reg_acc.addr == $past(addr_s);
  endproperty
  a_addr: assert property (p_addr) else $error("wrong register address");
  property p_pause;
    (state_reg == ahsp_pkg::ST_DIN) && rd_s && !due_reg |=> !o_din_take;
  endproperty
  a_pause: assert property (p_pause) else $error("word sent while host paused");
  property p_stop;
    (state_reg == ahsp_pkg::ST_DOUT) && wr_s |=> o_burst_stop && state_reg == ahsp_pkg::ST_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("burst not ended by stop");
  property p_bus;
    o_data_oe |-> $past(rd_act) || $past(state_reg == ahsp_pkg::ST_DIN);
  endproperty
  a_bus: assert property (p_bus) else $error("bus driven without cause");
  property p_rdy;
    !i_dout_ready |=> o_ddmardy_n;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready given while unable");
  property p_diag;
    o_is_master |=> !o_pdiag_oe;
  endproperty
  a_diag: assert property (p_diag) else $error("master drives diag line");
  property p_strobe;
    o_din_take |=> o_dstrobe != $past(o_dstrobe) ##1 $stable(o_dstrobe) [*2];
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe pacing broken");

  c_read: cover property (rd_pulse ##[1:20] !rd_act);
  c_din:  cover property (o_din_take ##[1:40] o_din_take);
  c_dout: cover property (o_dout_word.valid ##[1:40] o_burst_stop);
  c_irq:  cover property (o_intrq ##[1:50] !o_intrq);
endmodule

// ===== dv/ahsp_host_model.sv
// host controller model: register cycles, burst pin levels, data-out strobing
module ahsp_host_model (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_clk_link,
  input  wire logic [ahsp_pkg::DATA_W-1:0] i_bus,
  output logic                             o_cs_cmd_n,
  output logic                             o_cs_ctl_n,
  output logic      [ahsp_pkg::ADDR_W-1:0] o_addr,
  output logic                             o_rd_n,
  output logic                             o_wr_n,
  output logic                             o_dmack_n,
  output logic      [ahsp_pkg::DATA_W-1:0] o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    o_cs_cmd_n = 1'b1;
    o_cs_ctl_n = 1'b1;
    o_addr     = 3'h0;
    o_rd_n     = 1'b1;
    o_wr_n     = 1'b1;
    o_dmack_n  = 1'b1;
    o_data     = 16'h0000;
  end
  // register cycle: strobe held 6 cycles, read data taken at the last edge
  task automatic acc(input logic wr, input logic ctl, input logic [2:0] a,
                     input logic [15:0] wd, output logic [15:0] rd);
    @(posedge i_clk_sys);
    o_cs_cmd_n <= ctl;
    o_cs_ctl_n <= ~ctl;
    o_addr     <= a;
    if (wr)
    begin
      o_wr_n <= 1'b0;
      o_data <= wd;
    end
    else
      o_rd_n <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    rd = i_bus;
    o_rd_n <= 1'b1;
    o_wr_n <= 1'b1;
    // selects outlive the synchronised strobe rise
    repeat (4) @(posedge i_clk_sys);
    o_cs_cmd_n <= 1'b1;
    o_cs_ctl_n <= 1'b1;
    o_data     <= ~o_data;
    repeat (4) @(posedge i_clk_sys);
  endtask
  // burst levels: wr is the stop line, rd the host ready in data-in
  task automatic pins(input logic dmack_n, input logic wr_n, input logic rd_n);
    @(posedge i_clk_sys);
    o_dmack_n <= dmack_n;
    o_wr_n    <= wr_n;
    o_rd_n    <= rd_n;
  endtask
  // one word per strobe edge, edges far apart for the crossing
  task automatic dout(input logic [15:0] d);
    @(posedge i_clk_link);
    o_data <= d;
    repeat (3) @(posedge i_clk_link);
    o_rd_n <= ~o_rd_n;
    repeat (40) @(posedge i_clk_link);
    o_data <= ~d;
  endtask
endmodule

// ===== dv/testbench.sv
// self-checking bench of the device end of the host port
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, lclk = 1'b0, rst = 1'b1, hrst_n = 1'b1, csel = 1'b0;
  logic cs_cmd_n, cs_ctl_n, rd_n, wr_n, dmack_n, data_oe, ddmardy_n, dstrobe;
  logic intrq, intrq_oe, pdiag_n_o, pdiag_oe, dasp_n_o, dasp_oe, din_take;
  logic burst_stop, is_master, peer_diag_ok, peer_present;
  logic int_set = 0, int_en = 0, dev_sel = 0, srst = 0, sector_done = 0;
  logic diag_done = 0, active = 0, din_start = 0, din_valid = 0;
  logic dout_start = 0, dout_ready = 0, peer_pdiag = 0, peer_dasp = 0;
  logic [2:0]  addr;
  logic [15:0] h_data, dut_data, bus, rdv, din_data = 16'h3000, reg_rdata = 16'h0000;
  logic [15:0] words[4];
  ahsp_pkg::ahsp_reg_acc_s acc, last_acc;
  ahsp_pkg::ahsp_word_s    dword;
  int n_fail = 0, n_compared = 0, n_take = 0, n_strb = 0, n_word = 0, n_stop = 0, k;
  assign bus = data_oe ? dut_data : h_data;
  initial forever #20 clk = ~clk;
  initial
  begin
    #1.3;
    forever #3 lclk = ~lclk;
  end
  ahsp_host_model u_host (.i_clk_sys(clk), .i_clk_link(lclk), .i_bus(bus),
    .o_cs_cmd_n(cs_cmd_n), .o_cs_ctl_n(cs_ctl_n), .o_addr(addr), .o_rd_n(rd_n),
    .o_wr_n(wr_n), .o_dmack_n(dmack_n), .o_data(h_data));
  ahsp_top #(.PRESENCE_CYC(16)) u_dut (.i_clk_sys(clk), .i_sys_rst(rst),
    .i_clk_link(lclk), .i_hrst_n(hrst_n), .i_cs_cmd_n(cs_cmd_n), .i_cs_ctl_n(cs_ctl_n),
    .i_addr(addr), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_dmack_n(dmack_n), .i_csel(csel),
    .i_data(bus), .o_data(dut_data), .o_data_oe(data_oe), .o_ddmardy_n(ddmardy_n),
    .o_dstrobe(dstrobe), .o_intrq(intrq), .o_intrq_oe(intrq_oe),
    .i_pdiag_n(~(pdiag_oe | peer_pdiag)), .o_pdiag_n(pdiag_n_o), .o_pdiag_oe(pdiag_oe),
    .i_dasp_n(~(dasp_oe | peer_dasp)), .o_dasp_n(dasp_n_o), .o_dasp_oe(dasp_oe),
    .i_reg_rdata(reg_rdata), .o_reg_acc(acc), .i_int_set(int_set), .i_int_en(int_en),
    .i_dev_sel(dev_sel), .i_srst(srst), .i_sector_done(sector_done),
    .i_diag_done(diag_done), .i_active(active), .i_din_start(din_start),
    .i_din_valid(din_valid), .i_din_data(din_data), .o_din_take(din_take),
    .i_dout_start(dout_start), .i_dout_ready(dout_ready), .o_dout_word(dword),
    .o_burst_stop(burst_stop), .o_is_master(is_master),
    .o_peer_diag_ok(peer_diag_ok), .o_peer_present(peer_present));
  // ------------------------------------------------------------------
  // monitors
  // ------------------------------------------------------------------
  logic strb_q = 1'b0;
  always @(posedge clk)
  begin
    strb_q <= dstrobe;
    if (acc.valid === 1'b1) last_acc <= acc;
    if (din_take === 1'b1) n_take <= n_take + 1;
    if (din_take === 1'b1) din_data <= din_data + 16'h0001;
    if (!rst && dstrobe !== strb_q) n_strb <= n_strb + 1;
    if (burst_stop === 1'b1) n_stop <= n_stop + 1;
    if (dword.valid === 1'b1 && n_word < 4) words[n_word] <= dword.data;
    if (dword.valid === 1'b1) n_word <= n_word + 1;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (n_fail == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic do_reset(input logic c);
    rst  <= 1'b1;
    csel <= c;
    cyc(2);
    rst  <= 1'b0;
  endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_master();
    cyc(2);
    peer_dasp <= 1'b1;
    cyc(10);
    peer_dasp <= 1'b0;
    chk("is_master", is_master, 1);
    chk("peer_present", peer_present, 1);
    peer_pdiag <= 1'b1;
    cyc(6);
    chk("peer_diag_ok", peer_diag_ok, 1);
    chk("pdiag_oe_master", pdiag_oe, 0);
    chk("ddmardy_idle", ddmardy_n, 1);
  endtask
  task automatic t_regs();
    reg_rdata <= 16'h5a3c;
    u_host.acc(1'b0, 1'b0, 3'h3, 16'h0000, rdv);
    chk("rd_data", rdv, 16'h5a3c);
    chk("rd_blk", last_acc.ctl_blk, 0);
    chk("rd_addr", last_acc.addr, 3'h3);
    chk("rd_dir", last_acc.write, 0);
    u_host.acc(1'b1, 1'b1, 3'h6, 16'h0004, rdv);
    chk("wr_blk", last_acc.ctl_blk, 1);
    chk("wr_addr", last_acc.addr, 3'h6);
    chk("wr_data", last_acc.wdata, 16'h0004);
    chk("bus_free", data_oe, 0);
  endtask
  task automatic raise();
    @(posedge clk);
    int_set <= 1'b1;
    @(posedge clk);
    int_set <= 1'b0;
    cyc(3);
    chk("irq_set", intrq, 1);
  endtask
  task automatic t_irq();
    dev_sel <= 1'b1;
    int_en  <= 1'b1;
    raise();
    chk("irq_oe", intrq_oe, 1);
    u_host.acc(1'b0, 1'b0, 3'h7, 16'h0000, rdv);
    chk("irq_stat_rd", intrq, 0);
    raise();
    u_host.acc(1'b1, 1'b0, 3'h7, 16'h00ec, rdv);
    chk("irq_cmd_wr", intrq, 0);
    raise();
    sector_done <= 1'b1;
    cyc(1);
    sector_done <= 1'b0;
    cyc(3);
    chk("irq_sector", intrq, 0);
    raise();
    srst <= 1'b1;
    cyc(3);
    srst <= 1'b0;
    chk("irq_srst", intrq, 0);
    raise();
    hrst_n <= 1'b0;
    cyc(5);
    hrst_n <= 1'b1;
    cyc(4);
    chk("irq_hrst", intrq, 0);
    int_en <= 1'b0;
    cyc(3);
    chk("irq_oe_dis", intrq_oe, 0);
    int_en  <= 1'b1;
    dev_sel <= 1'b0;
    cyc(3);
    chk("irq_oe_unsel", intrq_oe, 0);
  endtask
  task automatic t_din();
    din_valid <= 1'b1;
    din_start <= 1'b1;
    u_host.pins(1'b0, 1'b0, 1'b0);
    cyc(40);
    chk("din_pace", 16'((n_take >= 8 && n_take <= 11)), 1);
    chk("din_strobe", 16'((n_strb >= n_take - 1 && n_strb <= n_take)), 1);
    chk("din_word", dut_data, din_data - 16'h0001);
    chk("din_oe", data_oe, 1);
    u_host.pins(1'b0, 1'b0, 1'b1);
    cyc(6);
    k = n_take;
    cyc(20);
    chk("din_pause", 16'(n_take - k), 0);
    u_host.pins(1'b0, 1'b1, 1'b1);
    cyc(8);
    chk("din_stop", 16'(n_stop), 1);
    din_start <= 1'b0;
    din_valid <= 1'b0;
    u_host.pins(1'b1, 1'b1, 1'b1);
    cyc(6);
  endtask
  task automatic t_dout();
    dout_start <= 1'b1;
    dout_ready <= 1'b1;
    u_host.pins(1'b0, 1'b0, 1'b1);
    cyc(8);
    chk("dout_ready", ddmardy_n, 0);
    for (int i = 0; i < 4; i++)
      u_host.dout(16'hc3a0 + 16'(i));
    cyc(100);
    chk("dout_count", 16'(n_word), 4);
    for (int i = 0; i < 4; i++)
      chk("dout_word", words[i], 16'hc3a0 + 16'(i));
    dout_ready <= 1'b0;
    cyc(4);
    chk("dout_pause", ddmardy_n, 1);
    u_host.pins(1'b0, 1'b1, 1'b1);
    cyc(8);
    chk("dout_stop", 16'(n_stop), 2);
    dout_start <= 1'b0;
    u_host.pins(1'b1, 1'b1, 1'b1);
  endtask
  task automatic t_slave();
    peer_pdiag <= 1'b0;
    do_reset(1'b1);
    cyc(6);
    chk("slave_present", dasp_oe, 1);
    chk("is_slave", is_master, 0);
    diag_done <= 1'b1;
    cyc(6);
    chk("slave_diag", pdiag_oe, 1);
    chk("pdiag_level", pdiag_n_o, 0);
    chk("dasp_level", dasp_n_o, 0);
    active <= 1'b1;
    cyc(20);
    chk("dasp_active", dasp_oe, 1);
    active <= 1'b0;
    cyc(3);
    chk("dasp_idle", dasp_oe, 0);
  endtask
  initial
  begin
    #1000000;
    n_fail++;
    end_sim();
  end
  initial
  begin
    do_reset(1'b0);
    t_master();
    t_regs();
    t_irq();
    t_din();
    t_dout();
    t_slave();
    end_sim();
  end
endmodule
